// ### design/pnd_next_data.sv
// Operation
// - With groups 2 and 3 on different triggers, group 3 next data sits at H'FFFA4, group 2 at H'FFFA6.
// - In split addressing the low nibble of H'FFFA4 and high nibble of H'FFFA6 ignore writes, read ones.
// - With a shared trigger the full byte sits at H'FFFA4 (group 3 high) and H'FFFA6 reads all ones.
// - Each enabled port A bit takes its next-data bit when its group's selected compare match occurs.
// - A port A bit whose enable is clear is never copied and holds its value.
// - Enabled port B bits take group 2/3 next data on the selected match; disabled bits hold.
// - Port A enable bit n gates next-data bit n onto port A bit n, pattern pin n.
// - Port B enable bits 7..0 gate next-data bits 15..8 onto port B bits 7..0, pins 15..8.
// - The port A enable register clears to H'00 on reset and hardware standby, not software standby.
// - The port B enable register clears to H'00 on reset and hardware standby, not software standby.
// - The trigger-select register sets to H'FF on reset and hardware standby, not software standby.
// - Bits 7:6 pick the match for pins 15..12: 00 channel 0, 01 channel 1, 1x channel 2.
// - Bits 5:4 pick the match for pins 11..8 with the same encoding.
// - Bits 3:2 pick the match for pins 7..4 with the same encoding.
// - Bits 1:0 pick the match for pins 3..0 with the same encoding.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module pnd_next_data
  import pnd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hw_standby,
  input wire logic [2:0] cm_strobe,
  input wire pnd_apb_req_s apb_req,
  output pnd_apb_rsp_s apb_rsp,
  output logic [15:0] pattern_pins
);

  // ==========================================================
  // State
  logic [7:0] en_a_q, en_a_d;
  logic [7:0] en_b_q, en_b_d;
  logic [7:0] trig_q, trig_d;
  logic [7:0] nxt_lo_q, nxt_lo_d;
  logic [7:0] nxt_up_q, nxt_up_d;
  logic [7:0] pa_q, pa_d;
  logic [7:0] pb_q, pb_d;
  logic [2:0] cm_q, cm_d;
  logic rdy_q, rdy_d;
  logic err_q, err_d;
  logic [7:0] rdat_q, rdat_d;

  logic [1:0] g3_f, g2_f, g1_f, g0_f;
  logic split_a, split_b;
  logic [3:0] fire;
  logic [7:0] mask_a, mask_b;
  logic setup, wr_en, hit;
  logic [31:0] addr;
  logic [7:0] wdat;

  // ==========================================================
  // Trigger selection
  assign g3_f = trig_q[G3_LSB +: 2];
  assign g2_f = trig_q[G2_LSB +: 2];
  assign g1_f = trig_q[G1_LSB +: 2];
  assign g0_f = trig_q[G0_LSB +: 2];
  // Pairs share a trigger when the channels agree
  assign split_a = pnd_chan(g1_f) != pnd_chan(g0_f);
  assign split_b = pnd_chan(g3_f) != pnd_chan(g2_f);
  // Group fire from the registered strobes
  assign fire[3] = pnd_fire(g3_f, cm_q);
  assign fire[2] = pnd_fire(g2_f, cm_q);
  assign fire[1] = pnd_fire(g1_f, cm_q);
  assign fire[0] = pnd_fire(g0_f, cm_q);
  // Per-bit transfer masks
  assign mask_a = {{4{fire[1]}}, {4{fire[0]}}} & en_a_q;
  assign mask_b = {{4{fire[3]}}, {4{fire[2]}}} & en_b_q;

  // ==========================================================
  // Bus decode
  assign addr = apb_req.paddr;
  assign wdat = apb_req.pwdata[7:0];
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && rdy_q;
  // Whole response driven by one assignment
  assign apb_rsp = '{pready: rdy_q, pslverr: err_q, prdata: {24'h000000, rdat_q}};
  assign pattern_pins = {pb_q, pa_q};

  // Read data captured in the setup cycle
  always_comb begin
    rdy_d = setup;
    hit = 1'b1;
    rdat_d = rdat_q;
    if (addr == pnd_addr(IDX_TRIG)) begin
      rdat_d = trig_q;
    end else if (addr == pnd_addr(IDX_EN_B)) begin
      rdat_d = en_b_q;
    end else if (addr == pnd_addr(IDX_EN_A)) begin
      rdat_d = en_a_q;
    end else if (addr == pnd_addr(IDX_NXT_UP_HI)) begin
      rdat_d = split_b ? {nxt_up_q[7:4], NIB_ONES} : nxt_up_q;
    end else if (addr == pnd_addr(IDX_NXT_UP_LO)) begin
      rdat_d = split_b ? {NIB_ONES, nxt_up_q[3:0]} : BYTE_ONES;
    end else if (addr == pnd_addr(IDX_NXT_LOW_HI)) begin
      rdat_d = split_a ? {nxt_lo_q[7:4], NIB_ONES} : nxt_lo_q;
    end else if (addr == pnd_addr(IDX_NXT_LOW_LO)) begin
      rdat_d = split_a ? {NIB_ONES, nxt_lo_q[3:0]} : BYTE_ONES;
    end else if (addr == pnd_addr(IDX_PORT_A)) begin
      rdat_d = pa_q;
    end else if (addr == pnd_addr(IDX_PORT_B)) begin
      rdat_d = pb_q;
    end else begin
      hit = 1'b0;
      rdat_d = 8'h00;
    end
    if (!setup) begin
      rdat_d = rdat_q;
    end
    err_d = setup ? !hit : (err_q && !rdy_q);
  end

  // ==========================================================
  // Register writes, transfers and standby clear
  always_comb begin
    en_a_d = en_a_q;
    en_b_d = en_b_q;
    trig_d = trig_q;
    nxt_lo_d = nxt_lo_q;
    nxt_up_d = nxt_up_q;
    pa_d = pa_q;
    pb_d = pb_q;
    cm_d = cm_strobe;
    if (wr_en) begin
      if (addr == pnd_addr(IDX_TRIG)) begin
        trig_d = wdat;
      end else if (addr == pnd_addr(IDX_EN_B)) begin
        en_b_d = wdat;
      end else if (addr == pnd_addr(IDX_EN_A)) begin
        en_a_d = wdat;
      end else if (addr == pnd_addr(IDX_NXT_UP_HI)) begin
        // Low nibble reserved when split
        nxt_up_d = split_b ? {wdat[7:4], nxt_up_q[3:0]} : wdat;
      end else if (addr == pnd_addr(IDX_NXT_UP_LO)) begin
        // Fully reserved when shared
        nxt_up_d = split_b ? {nxt_up_q[7:4], wdat[3:0]} : nxt_up_q;
      end else if (addr == pnd_addr(IDX_NXT_LOW_HI)) begin
        nxt_lo_d = split_a ? {wdat[7:4], nxt_lo_q[3:0]} : wdat;
      end else if (addr == pnd_addr(IDX_NXT_LOW_LO)) begin
        nxt_lo_d = split_a ? {nxt_lo_q[7:4], wdat[3:0]} : nxt_lo_q;
      end else if (addr == pnd_addr(IDX_PORT_A)) begin
        pa_d = (wdat & ~en_a_q) | (pa_q & en_a_q); // Enabled bits read-only
      end else if (addr == pnd_addr(IDX_PORT_B)) begin
        pb_d = (wdat & ~en_b_q) | (pb_q & en_b_q);
      end
    end
    // Copy only enabled bits of firing groups
    pa_d = (pa_d & ~mask_a) | (nxt_lo_q & mask_a);
    pb_d = (pb_d & ~mask_b) | (nxt_up_q & mask_b);
    if (hw_standby) begin
      en_a_d = RST_EN;
      en_b_d = RST_EN;
      trig_d = RST_TRIG;
      nxt_lo_d = RST_NXT;
      nxt_up_d = RST_NXT;
      pa_d = RST_PORT;
      pb_d = RST_PORT;
    end
  end

  // Register stage
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_a_q <= RST_EN;
      en_b_q <= RST_EN;
      trig_q <= RST_TRIG;
      nxt_lo_q <= RST_NXT;
      nxt_up_q <= RST_NXT;
      pa_q <= RST_PORT;
      pb_q <= RST_PORT;
      cm_q <= 3'h0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      en_a_q <= en_a_d;
      en_b_q <= en_b_d;
      trig_q <= trig_d;
      nxt_lo_q <= nxt_lo_d;
      nxt_up_q <= nxt_up_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      cm_q <= cm_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      rdat_q <= rdat_d;
    end
  end

  // ==========================================================
  // Checks
  logic wr_pa, wr_pb;
  assign wr_pa = wr_en && addr == pnd_addr(IDX_PORT_A);
  assign wr_pb = wr_en && addr == pnd_addr(IDX_PORT_B);

  a_porta_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && fire[0]) |=> ((pa_q[3:0] & $past(en_a_q[3:0]))
      == ($past(nxt_lo_q[3:0]) & $past(en_a_q[3:0]))))
    else $error("port A group 0 copy wrong");

  a_porta_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && !wr_pa) |=> ((pa_q & ~$past(en_a_q)) == ($past(pa_q) & ~$past(en_a_q))))
    else $error("disabled port A bit changed");

  a_portb_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && fire[2]) |=> ((pb_q[3:0] & $past(en_b_q[3:0]))
      == ($past(nxt_up_q[3:0]) & $past(en_b_q[3:0]))))
    else $error("port B group 2 copy wrong");

  a_portb_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && !wr_pb) |=> ((pb_q & ~$past(en_b_q)) == ($past(pb_q) & ~$past(en_b_q))))
    else $error("disabled port B bit changed");

  a_group3_chan2: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && trig_q[7:6] == 2'b10 && cm_q == 3'b100 && en_b_q[7:4] == 4'hF)
      |=> pb_q[7:4] == $past(nxt_up_q[7:4]))
    else $error("group 3 channel 2 trigger missed");

  // ==========================================================
  // Group copies, gating and decode checks
  a_group1_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && fire[1]) |=> ((pa_q[7:4] & $past(en_a_q[7:4]))
      == ($past(nxt_lo_q[7:4]) & $past(en_a_q[7:4]))))
    else $error("port A group 1 copy wrong");

  a_group3_copy: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && fire[3]) |=> ((pb_q[7:4] & $past(en_b_q[7:4]))
      == ($past(nxt_up_q[7:4]) & $past(en_b_q[7:4]))))
    else $error("port B group 3 copy wrong");

  // Both port A groups firing: enabled bits copied, the rest held
  a_enable_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && !wr_pa && fire[1] && fire[0]) |=> pa_q
      == (($past(pa_q) & ~$past(en_a_q)) | ($past(nxt_lo_q) & $past(en_a_q))))
    else $error("port A enable gating wrong");

  a_group0_chan0: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && trig_q[1:0] == 2'b00 && cm_q == 3'b001 && en_a_q[3:0] == 4'hF)
      |=> pa_q[3:0] == $past(nxt_lo_q[3:0]))
    else $error("group 0 channel 0 trigger missed");

  a_group2_chan1: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && trig_q[5:4] == 2'b01 && cm_q == 3'b010 && en_b_q[3:0] == 4'hF)
      |=> pb_q[3:0] == $past(nxt_up_q[3:0]))
    else $error("group 2 channel 1 trigger missed");

  a_split_hi_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    (setup && split_b && addr == pnd_addr(IDX_NXT_UP_HI)) |=> rdat_q[3:0] == NIB_ONES)
    else $error("split group 3 reserved nibble not ones");

  a_split_lo_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && split_b && wr_en && addr == pnd_addr(IDX_NXT_UP_LO))
      |=> nxt_up_q[7:4] == $past(nxt_up_q[7:4]))
    else $error("group 3 nibble written through group 2 address");

  a_shared_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && !split_b && wr_en && addr == pnd_addr(IDX_NXT_UP_HI))
      |=> nxt_up_q == $past(wdat))
    else $error("shared byte write lost");

  a_strobe_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> cm_q == $past(cm_strobe))
    else $error("match strobe not latched");

  // Zero wait states: ready in the cycle after every setup
  a_ready_next: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup |=> apb_rsp.pready)
    else $error("ready missing after setup");

  a_group1_none: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && !wr_pa && trig_q[3:2] == 2'b01 && !cm_q[1])
      |=> pa_q[7:4] == $past(pa_q[7:4]))
    else $error("group 1 moved without its match");

  a_split_ones: assert property (@(posedge core_clk) disable iff (!reset_n)
    (setup && split_b && addr == pnd_addr(IDX_NXT_UP_LO)) |=> rdat_q[7:4] == NIB_ONES)
    else $error("split reserved nibble not ones");

  a_split_ignore: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && split_b && wr_en && addr == pnd_addr(IDX_NXT_UP_HI))
      |=> nxt_up_q[3:0] == $past(nxt_up_q[3:0]))
    else $error("reserved nibble was written");

  a_shared_ones: assert property (@(posedge core_clk) disable iff (!reset_n)
    (setup && !split_b && addr == pnd_addr(IDX_NXT_UP_LO)) |=> rdat_q == BYTE_ONES)
    else $error("shared reserved byte not ones");

  a_standby_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    hw_standby |=> (en_a_q == RST_EN && en_b_q == RST_EN && trig_q == RST_TRIG))
    else $error("standby did not clear controls");

  a_copy_delay: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!hw_standby && !wr_pa && !wr_pb && cm_q == 3'b000 && cm_strobe != 3'b000)
      |=> (pa_q == $past(pa_q) && pb_q == $past(pb_q)) ##1 1'b1)
    else $error("copy happened at the strobe edge");

endmodule // pnd_next_data

// ### design/pnd_pkg.sv
package pnd_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [19:0] IDX_TRIG = 20'hFFFA1;
  localparam logic [19:0] IDX_EN_B = 20'hFFFA2;
  localparam logic [19:0] IDX_EN_A = 20'hFFFA3;
  localparam logic [19:0] IDX_NXT_UP_HI = 20'hFFFA4;
  localparam logic [19:0] IDX_NXT_LOW_HI = 20'hFFFA5;
  localparam logic [19:0] IDX_NXT_UP_LO = 20'hFFFA6;
  localparam logic [19:0] IDX_NXT_LOW_LO = 20'hFFFA7;
  localparam logic [19:0] IDX_PORT_A = 20'hFFFA8;
  localparam logic [19:0] IDX_PORT_B = 20'hFFFA9;

  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_NXT = 8'h00;
  localparam logic [7:0] RST_TRIG = 8'hFF;
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [3:0] NIB_ONES = 4'hF;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam int G3_LSB = 6;
  localparam int G2_LSB = 4;
  localparam int G1_LSB = 2;
  localparam int G0_LSB = 0;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pnd_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pnd_apb_rsp_s;

  // ==========================================================
  // Helpers
  // Byte address of a register index
  function automatic logic [31:0] pnd_addr(input logic [19:0] idx);
    return {10'h000, idx, 2'b00};
  endfunction

  // Timer channel chosen by a two-bit trigger field
  function automatic logic [1:0] pnd_chan(input logic [1:0] f);
    return f[1] ? 2'd2 : f;
  endfunction

  // Compare match of the chosen channel
  function automatic logic pnd_fire(input logic [1:0] f, input logic [2:0] cm);
    return cm[pnd_chan(f)];
  endfunction
endpackage

// ### tb/pnd_timer_model.sv
`timescale 1ns/10ps
// ==========================================================
// Timer channels: compare-match strobes one cycle after each request
module pnd_timer_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] fire,
  output logic [2:0] cm_strobe
);
  logic [2:0] cm_d;
  logic [2:0] cm_q;
  // Strobe follows fire one cycle later, for as long as fire is held
  always_comb cm_d = fire;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cm_q <= 3'h0;
    else cm_q <= cm_d;
  end
  assign cm_strobe = cm_q;
endmodule // pnd_timer_model

// ### tb/tb_pattern_next_data_transfer.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_pattern_next_data_transfer;
  import pnd_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hw_standby = 1'b0;
  logic [2:0] fire = 3'h0;
  logic [2:0] cm_strobe;
  pnd_apb_req_s apb_req = '0;
  pnd_apb_rsp_s apb_rsp;
  logic [15:0] pattern_pins;
  int mismatches = 0;
  int checks = 0;

  pnd_next_data pnd_next_data_inst (.core_clk(core_clk), .reset_n(reset_n),
    .hw_standby(hw_standby), .cm_strobe(cm_strobe), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pattern_pins(pattern_pins));
  pnd_timer_model pnd_timer_model_inst (.core_clk(core_clk), .reset_n(reset_n),
    .fire(fire), .cm_strobe(cm_strobe));

  // ==========================================================
  // Clock and watchdog
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end

  // ==========================================================
  // Bus and pulse tasks
  // One APB transfer, held until pready is seen
  task automatic apb(input logic [19:0] idx, input logic w, input logic [7:0] wd,
                     output logic [7:0] r, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, {10'h000, idx, 2'b00}, {24'h000000, wd}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    // Sample pready, data and error at the rising edge itself
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) mismatches++;
    r = apb_rsp.prdata[7:0];
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(idx, 1'b1, d, r, e);
  endtask
  task automatic rdc(input logic [19:0] idx, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(idx, 1'b0, 8'h00, r, e);
    `CHK(r, x)
  endtask
  // Match pulse; pins hold at the sampling edge, change one edge later
  task automatic pulse(input logic [2:0] m, input logic [15:0] x);
    logic [15:0] old;
    old = pattern_pins;
    @(posedge core_clk);
    fire <= m;
    @(posedge core_clk);
    fire <= 3'h0;
    @(posedge core_clk);
    #1;
    `CHK(pattern_pins, old)
    @(posedge core_clk);
    #1;
    `CHK(pattern_pins, x)
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] r;
    logic e;
    rdc(IDX_TRIG, 8'hFF);
    rdc(IDX_EN_A, 8'h00);
    rdc(IDX_EN_B, 8'h00);
    apb(20'h00010, 1'b0, 8'h00, r, e);
    `CHK(e, 1'b1)
    `CHK(r, 8'h00)
    $display("t_reset done");
  endtask
  task automatic t_split();
    wr(IDX_TRIG, 8'h1B);
    rdc(IDX_TRIG, 8'h1B);
    wr(IDX_NXT_UP_HI, 8'hA5);
    rdc(IDX_NXT_UP_HI, 8'hAF);
    wr(IDX_NXT_UP_LO, 8'h5C);
    rdc(IDX_NXT_UP_LO, 8'hFC);
    wr(IDX_NXT_LOW_HI, 8'h3C);
    rdc(IDX_NXT_LOW_HI, 8'h3C);
    rdc(IDX_NXT_LOW_LO, 8'hFF);
    $display("t_split done");
  endtask
  task automatic t_copy();
    wr(IDX_EN_A, 8'hF0);
    wr(IDX_EN_B, 8'h3C);
    pulse(3'b100, 16'h0030);
    pulse(3'b001, 16'h2030);
    pulse(3'b010, 16'h2C30);
    $display("t_copy done");
  endtask
  task automatic t_shared();
    wr(IDX_TRIG, 8'h5B);
    wr(IDX_NXT_UP_HI, 8'h96);
    rdc(IDX_NXT_UP_HI, 8'h96);
    rdc(IDX_NXT_UP_LO, 8'hFF);
    pulse(3'b010, 16'h1430);
    $display("t_shared done");
  endtask
  task automatic t_standby();
    @(posedge core_clk);
    hw_standby <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    hw_standby <= 1'b0;
    rdc(IDX_TRIG, 8'hFF);
    rdc(IDX_EN_A, 8'h00);
    rdc(IDX_EN_B, 8'h00);
    `CHK(pattern_pins, 16'h0000)
    $display("t_standby done");
  endtask
  // Channel 2 code 10, channel 1 on group 1, channel 0 on group 0, split pairs
  task automatic t_chan();
    wr(IDX_TRIG, 8'h94);
    wr(IDX_EN_B, 8'hFF);
    wr(IDX_EN_A, 8'hFF);
    wr(IDX_NXT_UP_HI, 8'h70);
    wr(IDX_NXT_UP_LO, 8'h09);
    wr(IDX_NXT_LOW_HI, 8'h50);
    wr(IDX_NXT_LOW_LO, 8'h06);
    rdc(IDX_NXT_LOW_HI, 8'h5F);
    rdc(IDX_NXT_LOW_LO, 8'hF6);
    pulse(3'b100, 16'h7000);
    pulse(3'b001, 16'h7006);
    pulse(3'b010, 16'h7956);
    wr(IDX_PORT_A, 8'hAA);
    rdc(IDX_PORT_A, 8'h56);
    wr(IDX_EN_A, 8'h0F);
    wr(IDX_PORT_A, 8'hAA);
    rdc(IDX_PORT_A, 8'hA6);
    $display("t_chan done");
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_split();
    t_copy();
    t_shared();
    t_standby();
    t_chan();
    print_verdict();
  end
endmodule // tb_pattern_next_data_transfer
